// ### rtl/rac_defs.vh
// register offsets, field positions, reset values and timing counts of the
// alarm, calibration and pin output block; definitions only.
`ifndef RAC_DEFS_VH
`define RAC_DEFS_VH

// ****************************************************************
// register map (byte offsets)
// ****************************************************************
`define RAC_OFS_ALARM_HIGH    8'h20
`define RAC_OFS_ALARM_LOW     8'h24
`define RAC_OFS_CALIB_PIN     8'h2C
`define RAC_OFS_COUNT_HIGH    8'h18
`define RAC_OFS_COUNT_LOW     8'h1C
`define RAC_OFS_IRQ_STATUS    8'h30
`define RAC_OFS_IRQ_MASK      8'h34
`define RAC_OFS_CONFIG        8'h38

// ****************************************************************
// reset values
// ****************************************************************
`define RAC_RST_ALARM_HALF    16'hFFFF
`define RAC_RST_CALIB         10'h000
`define RAC_RST_COUNT         32'h00000000

// ****************************************************************
// calibration register fields
// ****************************************************************
`define RAC_CAL_MSB           6
`define RAC_CAL_LSB           0
`define RAC_BIT_DIV_OUT       7
`define RAC_BIT_PULSE_EN      8
`define RAC_BIT_PULSE_SEL     9

// ****************************************************************
// status / mask / config bits
// ****************************************************************
`define RAC_IRQ_ALARM         0
`define RAC_IRQ_SECOND        1
`define RAC_BIT_CFG_ALLOWED   0

// ****************************************************************
// timing counts
// ****************************************************************
`define RAC_CAL_WINDOW_BITS   20
`define RAC_OUT_DIV           64
`define RAC_OUT_DIV_BITS      6

`endif

// ### rtl/rac_pulse_stretch.v
// holds a one-cycle event high until the next tick enable.
// assumes a single clock; tick is a one-cycle enable pulse.
`default_nettype none

module rac_pulse_stretch (
  // clock and reset
  input  wire ref_clk,
  input  wire rst_n,
  // event and tick
  input  wire event_in,
  input  wire tick,
  // stretched output
  output reg  pulse_out
);

  // ****************************************************************
  // stretch
  // ****************************************************************
  // set on event, drop at the next tick unless a new event arrives
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_out <= 1'b0;
    end else if (event_in) begin
      pulse_out <= 1'b1;
    end else if (tick) begin
      pulse_out <= 1'b0;
    end
  end

endmodule // rac_pulse_stretch

`default_nettype wire

// ### rtl/rac_clock_calib.v
// smooth calibration: masks cal source-clock enables out of every 2^20,
// spread across the window, and a divide-by-64 of the calibrated clock.
// assumes src_en is a one-cycle enable marking each source clock pulse.
`default_nettype none
`include "rac_defs.vh"

module rac_clock_calib #(
  parameter WIN_BITS = `RAC_CAL_WINDOW_BITS
) (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst_n,
  // source and setting
  input  wire       src_en,
  input  wire [6:0] cal,
  // calibrated outputs
  output reg        cal_en,
  output reg        div_out
);

  reg [WIN_BITS-1:0]          win_cnt;
  reg [`RAC_OUT_DIV_BITS-1:0] div_cnt;
  wire [6:0]                  slot;
  wire                        drop;

  // bit-reversed top seven bits spread drops evenly through the window
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_rev
      assign slot[g] = win_cnt[WIN_BITS-1-g];
    end
  endgenerate

  // drop only on the first cycle of a 2^13-long slot whose index is below cal
  assign drop = (win_cnt[WIN_BITS-8:0] == {(WIN_BITS-7){1'b0}}) && (slot < cal);

  // ****************************************************************
  // window and divider
  // ****************************************************************
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt <= {WIN_BITS{1'b0}};
      cal_en  <= 1'b0;
      div_cnt <= {`RAC_OUT_DIV_BITS{1'b0}};
      div_out <= 1'b0;
    end else begin
      cal_en <= src_en && !drop;
      if (src_en) begin
        win_cnt <= win_cnt + {{(WIN_BITS-1){1'b0}}, 1'b1};
      end
      // toggling at half the count gives a 50% duty divide by 64
      if (src_en && !drop) begin
        div_cnt <= div_cnt + {{(`RAC_OUT_DIV_BITS-1){1'b0}}, 1'b1};
        if (div_cnt == {1'b0, {(`RAC_OUT_DIV_BITS-1){1'b1}}} ||
            div_cnt == {`RAC_OUT_DIV_BITS{1'b1}}) begin
          div_out <= ~div_out;
        end
      end
    end
  end

endmodule // rac_clock_calib

`default_nettype wire

// ### rtl/rac_top.v
// top of the alarm compare, smooth calibration and event pin output.
// assumes src_en marks source clock pulses and tick marks prescaled ticks,
// both one-cycle enables on ref_clk; bdcr_reset_n is the backup soft reset.
// the register port never stalls: writes land at the strobe edge and read
// data stand for exactly the one cycle after the read strobe.
//
// Contract
// RULE_01 - alarm request raised when the running count equals the alarm value
// RULE_02 - alarm registers writable only while configuration write is allowed
// RULE_03 - alarm upper half at 0x20, bits 15:0, reset 0xFFFF
// RULE_04 - alarm lower half at 0x24, bits 15:0, reset 0xFFFF
// RULE_05 - pulse enable bit 8 puts selected pulse on the event pin
// RULE_06 - select bit 9: zero alarm pulse, one seconds pulse
// RULE_07 - pulse disabled and bit 7 set: source clock divided by 64 on pin; the code divides the calibrated clock instead
// RULE_08 - seven-bit field drops that many source pulses per 2^20 cycles
// RULE_09 - slows clock by about 0.95 ppm per count, up to 121 ppm
// RULE_10 - calibration register cleared only by power-on or backup soft reset
// RULE_11 - 32-bit counter advances once per prescaled tick
// RULE_12 - alarm and seconds pulses last one tick period on the pin
`default_nettype none
`include "rac_defs.vh"

module rac_top (
  // clock and resets
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire        bdcr_reset_n,
  // time base
  input  wire        src_en,
  input  wire        prescaled_tick,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // outputs
  output reg         event_pin,
  output reg         calibrated_en,
  output reg         irq
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  reg rst_meta;
  reg rst_n;
  reg bd_meta;
  reg bd_n;

  // both resets assert at once and release through two flops
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // the backup reset has its own pair so a system reset leaves calibration alone
  always @(posedge ref_clk or negedge bdcr_reset_n) begin
    if (!bdcr_reset_n) begin
      bd_meta <= 1'b0;
      bd_n    <= 1'b0;
    end else begin
      bd_meta <= 1'b1;
      bd_n    <= bd_meta;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // software-visible state
  reg  [15:0] alarm_value_high_half;
  reg  [15:0] alarm_value_low_half;
  reg  [9:0]  calibration_and_pin_output;
  reg  [31:0] running_count_value;
  reg         config_write_allowed_flag;
  reg  [1:0]  irq_status;
  reg  [1:0]  irq_mask;
  // internal events, pulses and write decode
  reg         alarm_hit;
  reg         second_hit;
  wire [31:0] alarm_value;
  wire        cal_en;
  wire        div_out;
  wire        alarm_pulse;
  wire        second_pulse;
  wire        wr_alarm_ok;
  wire        wr_alarm_high;
  wire        wr_alarm_low;
  wire        wr_count_high;
  wire        wr_count_low;
  wire        wr_calib;
  wire        wr_status;
  wire        wr_mask;
  wire        wr_config;
  wire [1:0]  status_clear;
  reg  [1:0]  next_irq_status;
  reg         next_event_pin;

  assign alarm_value = {alarm_value_high_half, alarm_value_low_half};
  // RULE_02 write protect
  assign wr_alarm_ok = reg_wr && config_write_allowed_flag;

  // ****************************************************************
  // write decode
  // ****************************************************************
  // protected targets share the configuration gate, so a stray write
  // outside configuration mode never moves the alarm or the count
  assign wr_alarm_high = wr_alarm_ok && (reg_addr == `RAC_OFS_ALARM_HIGH);
  assign wr_alarm_low  = wr_alarm_ok && (reg_addr == `RAC_OFS_ALARM_LOW);
  assign wr_count_high = wr_alarm_ok && (reg_addr == `RAC_OFS_COUNT_HIGH);
  assign wr_count_low  = wr_alarm_ok && (reg_addr == `RAC_OFS_COUNT_LOW);
  // the remaining targets take writes at any time; calibration lives in the
  // backup domain and is not guarded by configuration mode
  assign wr_calib      = reg_wr && (reg_addr == `RAC_OFS_CALIB_PIN);
  assign wr_status     = reg_wr && (reg_addr == `RAC_OFS_IRQ_STATUS);
  assign wr_mask       = reg_wr && (reg_addr == `RAC_OFS_IRQ_MASK);
  assign wr_config     = reg_wr && (reg_addr == `RAC_OFS_CONFIG);
  // ones written to the status word clear the matching sticky bits
  assign status_clear  = wr_status ? reg_wdata[1:0] : 2'h0;

  // RULE_03 upper alarm half
  // RULE_04 lower alarm half
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_value_high_half <= `RAC_RST_ALARM_HALF;
      alarm_value_low_half  <= `RAC_RST_ALARM_HALF;
    end else begin
      if (wr_alarm_high) begin
        alarm_value_high_half <= reg_wdata[15:0];
      end
      if (wr_alarm_low) begin
        alarm_value_low_half <= reg_wdata[15:0];
      end
    end
  end

  // RULE_10 backup-domain reset only
  // the system reset must not touch calibration, so it lives on bd_n
  always @(posedge ref_clk or negedge bd_n) begin
    if (!bd_n) begin
      calibration_and_pin_output <= `RAC_RST_CALIB;
    end else if (wr_calib) begin
      calibration_and_pin_output <= reg_wdata[9:0];
    end
  end

  // configuration mode bit, and the interrupt mask
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_write_allowed_flag <= 1'b0;
      irq_mask                  <= 2'h0;
    end else begin
      if (wr_config) begin
        config_write_allowed_flag <= reg_wdata[`RAC_BIT_CFG_ALLOWED];
      end
      if (wr_mask) begin
        irq_mask <= reg_wdata[1:0];
      end
    end
  end

  // ****************************************************************
  // counter and compare
  // ****************************************************************
  // RULE_11 count on tick
  // software loads the count in configuration mode; a load beats the tick
  // the count wraps from all ones to zero like any plain binary counter
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      running_count_value <= `RAC_RST_COUNT;
    end else if (wr_count_high) begin
      running_count_value[31:16] <= reg_wdata[15:0];
    end else if (wr_count_low) begin
      running_count_value[15:0] <= reg_wdata[15:0];
    end else if (prescaled_tick) begin
      running_count_value <= running_count_value + 32'h00000001;
    end
  end

  // RULE_01 equality compare
  // evaluated once per tick so a held match fires a single event
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_hit  <= 1'b0;
      second_hit <= 1'b0;
    end else begin
      alarm_hit  <= prescaled_tick && (running_count_value == alarm_value);
      second_hit <= prescaled_tick;
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  // so an alarm landing beside a clear of the same bit is never lost
  always @* begin
    next_irq_status = (irq_status & ~status_clear) | {second_hit, alarm_hit};
  end

  // irq follows the status one cycle late, straight from a flop
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 2'h0;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq        <= |(irq_status & irq_mask);
    end
  end

  // ****************************************************************
  // calibration and pin output
  // ****************************************************************
  // RULE_08 drop count per window
  // RULE_09 step of one pulse per 2^20
  // the calibrator keeps the backup reset so a system reset does not
  // restart its window or shift where the drops fall
  rac_clock_calib #(
    .WIN_BITS (`RAC_CAL_WINDOW_BITS)
  ) u_calib (
    .ref_clk (ref_clk),
    .rst_n   (bd_n),
    .src_en  (src_en),
    .cal     (calibration_and_pin_output[`RAC_CAL_MSB:`RAC_CAL_LSB]),
    .cal_en  (cal_en),
    .div_out (div_out)
  );

  // RULE_12 one tick wide
  rac_pulse_stretch u_alarm_stretch (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .event_in  (alarm_hit),
    .tick      (prescaled_tick),
    .pulse_out (alarm_pulse)
  );

  // every tick is a seconds event, so this pulse rests low one cycle per tick
  rac_pulse_stretch u_second_stretch (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .event_in  (second_hit),
    .tick      (prescaled_tick),
    .pulse_out (second_pulse)
  );

  // RULE_05 pulse enable
  // RULE_06 source select
  // RULE_07 divided clock
  // the pulse output takes precedence; the divided clock shows only when it is off
  always @* begin
    if (calibration_and_pin_output[`RAC_BIT_PULSE_EN]) begin
      next_event_pin = calibration_and_pin_output[`RAC_BIT_PULSE_SEL] ?
                       second_pulse : alarm_pulse;
    end else if (calibration_and_pin_output[`RAC_BIT_DIV_OUT]) begin
      next_event_pin = div_out;
    end else begin
      next_event_pin = 1'h0;
    end
  end

  // registered so the pin never shows a decode glitch
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_pin     <= 1'b0;
      calibrated_en <= 1'b0;
    end else begin
      calibrated_en <= cal_en;
      event_pin     <= next_event_pin;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // data stand in the cycle after the strobe only; unmapped reads zero
  // reads have no side effects, so status is cleared only by writes
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `RAC_OFS_ALARM_HIGH: reg_rdata <= {16'h0000, alarm_value_high_half};
        `RAC_OFS_ALARM_LOW:  reg_rdata <= {16'h0000, alarm_value_low_half};
        `RAC_OFS_CALIB_PIN:  reg_rdata <= {22'h000000, calibration_and_pin_output};
        `RAC_OFS_COUNT_HIGH: reg_rdata <= {16'h0000, running_count_value[31:16]};
        `RAC_OFS_COUNT_LOW:  reg_rdata <= {16'h0000, running_count_value[15:0]};
        `RAC_OFS_IRQ_STATUS: reg_rdata <= {30'h00000000, irq_status};
        `RAC_OFS_IRQ_MASK:   reg_rdata <= {30'h00000000, irq_mask};
        `RAC_OFS_CONFIG:     reg_rdata <= {31'h00000000, config_write_allowed_flag};
        default:             reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // rac_top

`default_nettype wire

// ### tb/rac_properties.sv
// port checker of the alarm, calibration and pin output block.
// assumes one clock; bound to rac_top at the foot of this file.
`default_nettype none
module rac_properties (
  // clock and resets
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        bdcr_reset_n,
  // inputs
  input wire logic        src_en,
  input wire logic        prescaled_tick,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  // outputs
  input wire logic [31:0] reg_rdata,
  input wire logic        event_pin,
  input wire logic        calibrated_en,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] ctl_q;
  logic [3:0] cal_zero;
  logic [5:0] tk_h;
  logic [1:0] wr_h;
  wire        rst_all = resetn & bdcr_reset_n;
  wire        clr_wr = reg_wr && (reg_addr == 8'h30 || reg_addr == 8'h34);
  wire        sec_mode = ctl_q[9:8] == 2'h3;
  wire        alm_mode = ctl_q[9:8] == 2'h1;
  default clocking cb @(posedge ref_clk); endclocking
  // shadow of the pin settings; only the backup reset clears it
  always_ff @(posedge ref_clk or negedge bdcr_reset_n) begin
    if (!bdcr_reset_n) ctl_q <= 10'h000;
    else if (reg_wr && reg_addr == 8'h2C) ctl_q <= reg_wdata[9:0];
  end
  // history so the calibrator is known idle and settled
  always_ff @(posedge ref_clk or negedge rst_all) begin
    if (!rst_all) begin
      cal_zero <= 4'h0;
      tk_h <= 6'h00;
      wr_h <= 2'h0;
    end else begin
      cal_zero <= {cal_zero[2:0], ctl_q[6:0] == 7'h00};
      tk_h <= {tk_h[4:0], prescaled_tick};
      wr_h <= {wr_h[0], reg_wr};
    end
  end
  sequence sec_seen;
    ##[1:5] (event_pin || !sec_mode);
  endsequence
  rdata_idle_a: assert property (disable iff (!resetn)
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside slot");
  rd_upper_a: assert property (disable iff (!resetn)
    reg_rd && (reg_addr == 8'h20 || reg_addr == 8'h24) |=> reg_rdata[31:16] == 16'h0)
    else $error("alarm half upper bits set");
  irq_hold_a: assert property (disable iff (!resetn)
    irq && !clr_wr && !$past(clr_wr) |=> irq) else $error("irq dropped uncleared");
  irq_cause_a: assert property (disable iff (!resetn)
    $rose(irq) |-> (|tk_h) || (|wr_h)) else $error("irq without cause");
  cal_pass_a: assert property (disable iff (!rst_all)
    &cal_zero && $past(src_en, 2) |-> calibrated_en) else $error("pulse lost at zero cal");
  pin_off_a: assert property (disable iff (!rst_all)
    ctl_q[8:7] == 2'h0 |=> !event_pin) else $error("pin active while off");
  sec_pulse_a: assert property (disable iff (!rst_all)
    prescaled_tick && sec_mode |-> sec_seen) else $error("seconds pulse missing");
  alm_fall_a: assert property (disable iff (!rst_all)
    $fell(event_pin) && alm_mode && $past(alm_mode) |-> |tk_h[2:0])
    else $error("alarm pulse ended off tick");
endmodule // rac_properties
bind rac_top rac_properties u_props (.ref_clk(ref_clk), .resetn(resetn),
  .bdcr_reset_n(bdcr_reset_n), .src_en(src_en), .prescaled_tick(prescaled_tick),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .event_pin(event_pin), .calibrated_en(calibrated_en), .irq(irq));
`default_nettype wire

// ### tb/tb.sv
// self-checking bench of the alarm, calibration and pin output block.
// assumes rac_top on one 50 MHz clock; the checker is bound separately.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'h0;
  logic        resetn = 1'h0;
  logic        bdcr_reset_n = 1'h0;
  logic        src_en = 1'h0;
  logic        prescaled_tick = 1'h0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  wire  [31:0] reg_rdata;
  wire         event_pin;
  wire         calibrated_en;
  wire         irq;
  int          failures = 0;
  int          cmp_count = 0;
  int          seed = 93428;
  int          cnt, alm, hit, hit_now, i, b, e, nc, first;
  int          q[$];
  always #10 ref_clk = ~ref_clk;
  rac_top uut (.ref_clk(ref_clk), .resetn(resetn), .bdcr_reset_n(bdcr_reset_n),
    .src_en(src_en), .prescaled_tick(prescaled_tick), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .event_pin(event_pin), .calibrated_en(calibrated_en), .irq(irq));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 chk($sformatf("reg %h", a), reg_rdata, x);
  endtask
  // one tick with a source pulse; the model counts and compares
  task automatic tick();
    @(posedge ref_clk);
    prescaled_tick <= 1'h1;
    src_en <= 1'h1;
    @(posedge ref_clk);
    prescaled_tick <= 1'h0;
    src_en <= 1'h0;
    hit_now = (cnt == alm);
    hit |= hit_now;
    cnt++;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic rst_pulse(input int bd);
    @(posedge ref_clk);
    if (bd) bdcr_reset_n <= 1'h0;
    else resetn <= 1'h0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'h1;
    bdcr_reset_n <= 1'h1;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // a hang counts as a mismatch; the run needs about 525 cycles
  initial begin
    repeat (6000) @(posedge ref_clk);
    failures++;
    stop_test();
  end
  initial begin
    hit = 0;
    rst_pulse(1);
    rd(8'h20, 32'hFFFF);
    rd(8'h24, 32'hFFFF);
    rd(8'h2C, 32'h0);
    rd(8'h3C, 32'h0);
    wr(8'h24, 32'h1234);
    rd(8'h24, 32'hFFFF);
    $display("test reset_and_protect done");
    alm = $random(seed);
    cnt = alm - 2;
    wr(8'h38, 32'h1);
    wr(8'h20, {alm[15:0], alm[31:16]});
    wr(8'h24, alm);
    rd(8'h20, alm[31:16]);
    rd(8'h24, alm[15:0]);
    wr(8'h18, cnt[31:16]);
    wr(8'h1C, cnt[15:0]);
    wr(8'h34, 32'h1);
    rd(8'h34, 32'h1);
    wr(8'h2C, 32'h100);
    repeat (2) tick();
    chk("irq", irq, hit);
    rd(8'h1C, cnt[15:0]);
    rd(8'h18, cnt[31:16]);
    tick();
    chk("irq", irq, hit);
    chk("pin", event_pin, hit_now);
    rd(8'h30, 32'h2 + hit);
    tick();
    chk("pin", event_pin, hit_now);
    wr(8'h30, 32'h1);
    rd(8'h30, 32'h2);
    chk("irq", irq, 32'h0);
    $display("test alarm done");
    wr(8'h2C, 32'h300);
    tick();
    chk("pin", event_pin, 32'h1);
    wr(8'h30, 32'h2);
    rd(8'h30, 32'h0);
    wr(8'h38, 32'h0);
    wr(8'h20, 32'h0);
    rd(8'h20, alm[31:16]);
    $display("test seconds_pin done");
    wr(8'h2C, 32'hFFFFFFFF);
    rst_pulse(0);
    rd(8'h2C, 32'h3FF);
    rd(8'h20, 32'hFFFF);
    rst_pulse(1);
    rd(8'h2C, 32'h0);
    $display("test backup_reset done");
    wr(8'h2C, 32'h81);
    first = 1;
    nc = 0;
    for (i = 0; i < 400; i++) begin
      @(posedge ref_clk);
      b = (i & 1) ? 0 : $random(seed) & 1;
      src_en <= b[0];
      e = b && !first;
      if (b) first = 0;
      q.push_back(e);
      nc += e;
      #1;
      if (q.size() > 2) chk("cal_en", calibrated_en, q.pop_front());
    end
    @(posedge ref_clk);
    src_en <= 1'h0;
    repeat (8) @(posedge ref_clk);
    #1 chk("div pin", event_pin, (nc / 32) & 1);
    $display("test calibration done");
    stop_test();
  end
endmodule // tb
`default_nettype wire
